/* File: rtl/irq_timer_pkg.sv */
// Constants, field positions and states of the interrupt and timer unit.
// Assumes an 8-bit register port driven by the core's register file logic.
// Overview of operation
// - Six requests, individual and global masking
// - Priority register orders simultaneous pending requests
// - Grant: disable, push PC, flags, jump
// - Request n vector at bytes 2n, 2n+1
// - Request register readable even when masked
// - Comparators feed line one and two requests
// - Line three and coprocessor trigger falling
// - Request bits 7:6 select line edges
// - Two 8-bit counters, 6-bit prescalers
// - Count 1 to 256, end raises request
// - Single pass or modulo-n continuous mode
// - Start, stop, continue, restart from load
// - Counter readable undisturbed, prescaler not readable
// - Timer zero clocked internally only
// - Timer one: internal/4 or external line
// - External input: clock, triggers or gate
// - Timer zero output can clock timer one
// - Timer one input line one, output line six
// - Coprocessor sets request; write one clears
package irq_timer_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_COPROC_CTRL = 8'hEC;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'hF1;
  localparam logic [7:0] ADDR_T1_COUNT = 8'hF2;
  localparam logic [7:0] ADDR_T1_PRESCALE = 8'hF3;
  localparam logic [7:0] ADDR_T0_COUNT = 8'hF4;
  localparam logic [7:0] ADDR_T0_PRESCALE = 8'hF5;
  localparam logic [7:0] ADDR_PRIORITY = 8'hF9;
  localparam logic [7:0] ADDR_REQUEST = 8'hFA;
  localparam logic [7:0] ADDR_MASK = 8'hFB;

  // Request bit positions
  localparam int REQ_LINE2 = 0;
  localparam int REQ_LINE3 = 1;
  localparam int REQ_LINE1 = 2;
  localparam int REQ_COPROC = 3;
  localparam int REQ_T0 = 4;
  localparam int REQ_T1 = 5;
  localparam int NUM_REQ = 6;

  // Request register edge select fields
  localparam int EDGE_SEL_HI = 7;
  localparam int EDGE_SEL_LO = 6;
  // Mask register global enable
  localparam int MASK_GLOBAL = 7;
  // Coprocessor control request flag
  localparam int COPROC_REQ_BIT = 0;

  // Timer mode register fields
  localparam int TM_LOAD0 = 0;
  localparam int TM_EN0 = 1;
  localparam int TM_LOAD1 = 2;
  localparam int TM_EN1 = 3;
  localparam int TM_EXT_LO = 4;
  localparam int TM_EXT_HI = 5;
  localparam int TM_T1_EXT = 6;
  localparam int TM_CASCADE = 7;

  // Prescaler register fields
  localparam int PRE_CONT = 0;
  localparam int PRE_VAL_LO = 2;
  localparam int PRE_VAL_HI = 7;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Internal clock divider for timer ticks
  localparam int INT_CLK_DIV = 4;

  // External timer input modes
  typedef enum logic [1:0] {
    EXT_CLOCK = 2'b00,
    EXT_GATE = 2'b01,
    EXT_TRIG_ONCE = 2'b10,
    EXT_TRIG_RETRIG = 2'b11
  } ext_mode_t;

  // Interrupt machine cycle states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PUSH_PC = 3'b001,
    S_PUSH_FLAGS = 3'b010,
    S_FETCH_HI = 3'b011,
    S_FETCH_LO = 3'b100,
    S_JUMP = 3'b101
  } int_state_t;

endpackage

/* File: rtl/counter_timer.sv */
// Down counter with its own prescaler, used for both timers.
// Assumes tick, load and enable are one-clock qualified inputs.
`timescale 1ns/1ns
module counter_timer
  import irq_timer_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int PRE_W = 6
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic i_enable,
  input wire logic i_continuous,
  input wire logic [CNT_W-1:0] i_init,
  input wire logic [PRE_W-1:0] i_prescale,
  // Status
  output logic [CNT_W-1:0] o_count,
  output logic o_end,
  output logic o_running
);

  // Refuse widths the end-of-count compare cannot serve
  if (CNT_W < 2 || PRE_W < 1) begin : g_bad_width
    $error("counter_timer: widths too small");
  end

  logic [PRE_W-1:0] pre; // Prescaler, not visible to software
  logic [PRE_W-1:0] next_pre;
  logic [CNT_W-1:0] next_count;
  logic next_end;
  logic next_running;

  // Prescaler and counter next state
  always_comb begin
    next_pre = pre;
    next_count = o_count;
    next_end = 1'b0;
    next_running = o_running;
    if (i_load) begin
      // Restart from the load value
      next_count = i_init;
      next_pre = i_prescale - 1'b1; // Zero wraps to full divide
      next_running = 1'b1;
    end else if (o_running && i_enable && i_tick) begin
      if (pre == '0) begin
        next_pre = i_prescale - 1'b1;
        // Load of zero counts 256 ticks before ending
        next_count = o_count - 1'b1;
        if (o_count == CNT_W'(1)) begin
          next_end = 1'b1;
          if (i_continuous) begin
            next_count = i_init; // Modulo-n reload
          end else begin
            next_running = 1'b0; // Single pass stops at zero
          end
        end
      end else begin
        next_pre = pre - 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre <= '0;
      o_count <= '0;
      o_end <= 1'b0;
      o_running <= 1'b0;
    end else begin
      pre <= next_pre;
      o_count <= next_count;
      o_end <= next_end;
      o_running <= next_running;
    end
  end

endmodule

/* File: rtl/vectored_irq_and_timer_unit.sv */
// Interrupt request, mask, priority and vector logic plus two timers.
// Assumes the core reads and writes registers through a one-cycle port,
// and program memory returns vector bytes one clock after the address.
`timescale 1ns/1ns
module vectored_irq_and_timer_unit
  import irq_timer_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Port lines and comparators
  input wire logic i_port3_line_one,
  input wire logic i_port3_line_two,
  input wire logic i_port3_line_three,
  input wire logic i_comparator_one_out,
  input wire logic i_comparator_two_out,
  input wire logic i_analog_mode,
  // Coprocessor request, level, acts on falling edge
  input wire logic i_req_from_coprocessor,
  // Core interrupt machine cycle
  input wire logic i_instr_boundary,
  input wire logic [7:0] i_vec_data,
  output logic o_int_cycle,
  output logic o_push_pc,
  output logic o_push_flags,
  output logic o_vec_rd,
  output logic [15:0] o_vec_addr,
  output logic [15:0] o_handler_addr,
  output logic o_jump,
  // Timer one output pin
  output logic o_timer_output
);

  // Edge detector, shared by the line and coprocessor request sources
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rise_en,
                                    input logic fall_en);
    edge_hit = (rise_en && !prev && cur) || (fall_en && prev && !cur);
  endfunction

  // Software visible state
  logic [7:0] req_reg; // Request register with edge select
  logic [7:0] mask_reg;
  logic [7:0] prio_reg;
  logic [7:0] mode_reg;
  logic [7:0] t0_init;
  logic [7:0] t1_init;
  logic [7:0] t0_pre;
  logic [7:0] t1_pre;
  logic [7:0] next_req_reg;
  logic [7:0] next_mask_reg;
  logic [7:0] next_prio_reg;
  logic [7:0] next_mode_reg;
  logic [7:0] next_t0_init;
  logic [7:0] next_t1_init;
  logic [7:0] next_t0_pre;
  logic [7:0] next_t1_pre;
  logic [7:0] next_rdata;

  // Previous input levels for edge detection
  logic prev_src1;
  logic prev_src2;
  logic prev_src3;
  logic prev_coproc;
  logic prev_ext;

  // Internal clock divided by four
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic div_tick;

  // Timer connections
  logic [7:0] t0_count;
  logic [7:0] t1_count;
  logic t0_end;
  logic t1_end;
  logic t0_running;
  logic t1_running;
  logic t1_tick;
  logic t1_load;
  logic next_timer_output;

  // Interrupt machine
  int_state_t state;
  int_state_t next_state;
  logic [2:0] vec_idx;
  logic [2:0] next_vec_idx;
  logic [7:0] vec_hi;
  logic [7:0] next_vec_hi;
  logic [15:0] next_handler;
  logic grant;
  logic [2:0] grant_idx;
  logic [NUM_REQ-1:0] set_req;
  logic src1;
  logic src2;
  logic ext_rise;
  logic ext_fall;
  logic wr_hit_req;

  // Comparators replace the line one and two request levels in analog mode
  assign src1 = i_analog_mode ? i_comparator_one_out : i_port3_line_one;
  assign src2 = i_analog_mode ? i_comparator_two_out : i_port3_line_two;
  assign div_tick = (div_cnt == 2'(INT_CLK_DIV - 1));
  // Timer one input always comes from line one
  assign ext_rise = !prev_ext && i_port3_line_one;
  assign ext_fall = prev_ext && !i_port3_line_one;
  assign wr_hit_req = i_reg_wr && (i_reg_addr == ADDR_REQUEST);

  // Qualifying events per request
  always_comb begin
    set_req = '0;
    // Edge select table on bits 7:6
    set_req[REQ_LINE1] = edge_hit(prev_src1, src1, req_reg[EDGE_SEL_HI],
      !req_reg[EDGE_SEL_HI] || req_reg[EDGE_SEL_LO]);
    set_req[REQ_LINE2] = edge_hit(prev_src2, src2, req_reg[EDGE_SEL_LO],
      !req_reg[EDGE_SEL_LO] || req_reg[EDGE_SEL_HI]);
    // Falling edges only
    set_req[REQ_LINE3] = edge_hit(prev_src3, i_port3_line_three,
      1'b0, 1'b1);
    set_req[REQ_COPROC] = edge_hit(prev_coproc, i_req_from_coprocessor,
      1'b0, 1'b1);
    set_req[REQ_T0] = t0_end;
    set_req[REQ_T1] = t1_end;
  end

  // Priority pick: scan upward from the top index, wrapping
  always_comb begin
    logic [2:0] top;
    logic [3:0] idx; // One bit more, top plus k reaches ten
    logic [NUM_REQ-1:0] live;
    top = (prio_reg[2:0] < 3'(NUM_REQ)) ? prio_reg[2:0] : 3'h0;
    idx = 4'h0;
    // Masked individually here; the global enable gates the grant below
    live = req_reg[NUM_REQ-1:0] & mask_reg[NUM_REQ-1:0];
    grant = 1'b0;
    grant_idx = 3'h0;
    for (int k = NUM_REQ - 1; k >= 0; k--) begin
      idx = {1'b0, top} + 4'(k);
      if (idx >= 4'(NUM_REQ)) begin
        idx = idx - 4'(NUM_REQ);
      end
      if (live[idx[2:0]]) begin
        grant_idx = idx[2:0]; // Lowest k wins
        grant = 1'b1;
      end
    end
    grant = grant && mask_reg[MASK_GLOBAL] && i_instr_boundary &&
      (state == S_IDLE);
  end

  // Register file next values
  always_comb begin
    next_req_reg = req_reg;
    next_mask_reg = mask_reg;
    next_prio_reg = prio_reg;
    next_mode_reg = mode_reg;
    next_t0_init = t0_init;
    next_t1_init = t1_init;
    next_t0_pre = t0_pre;
    next_t1_pre = t1_pre;
    // Load commands act for one clock only
    next_mode_reg[TM_LOAD0] = 1'b0;
    next_mode_reg[TM_LOAD1] = 1'b0;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_REQUEST: next_req_reg = i_reg_wdata;
        ADDR_MASK: next_mask_reg = i_reg_wdata;
        ADDR_PRIORITY: next_prio_reg = i_reg_wdata;
        // Start, stop, continue, reload
        ADDR_TIMER_MODE: next_mode_reg = i_reg_wdata;
        ADDR_T0_COUNT: next_t0_init = i_reg_wdata;
        ADDR_T1_COUNT: next_t1_init = i_reg_wdata;
        ADDR_T0_PRESCALE: next_t0_pre = i_reg_wdata;
        ADDR_T1_PRESCALE: next_t1_pre = i_reg_wdata;
        ADDR_COPROC_CTRL: begin
          // Write one clears the coprocessor request
          if (i_reg_wdata[COPROC_REQ_BIT]) begin
            next_req_reg[REQ_COPROC] = 1'b0;
          end
        end
        default: begin
          // Other addresses belong elsewhere
        end
      endcase
    end
    if (grant) begin
      // Granted request leaves pending state
      next_req_reg[grant_idx] = 1'b0;
      // Machine cycle blocks further interrupts
      next_mask_reg[MASK_GLOBAL] = 1'b0;
    end
    // Events win over any clear in the same cycle
    next_req_reg[NUM_REQ-1:0] = next_req_reg[NUM_REQ-1:0] | set_req;
  end

  // Read data, registered every clock
  always_comb begin
    next_rdata = 8'h00;
    unique case (i_reg_addr)
      ADDR_REQUEST: next_rdata = req_reg; // Pending even if masked
      ADDR_MASK: next_rdata = mask_reg;
      ADDR_PRIORITY: next_rdata = prio_reg;
      ADDR_TIMER_MODE: next_rdata = mode_reg;
      // Live count, read without side effects
      ADDR_T0_COUNT: next_rdata = t0_count;
      ADDR_T1_COUNT: next_rdata = t1_count;
      ADDR_COPROC_CTRL: next_rdata[COPROC_REQ_BIT] = req_reg[REQ_COPROC];
      // Prescalers read as zero
      default: next_rdata = 8'h00;
    endcase
  end

  // Register file and edge history
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req_reg <= RST_REG;
      mask_reg <= RST_REG;
      prio_reg <= RST_REG;
      mode_reg <= RST_REG;
      t0_init <= RST_REG;
      t1_init <= RST_REG;
      t0_pre <= RST_REG;
      t1_pre <= RST_REG;
      o_reg_rdata <= RST_REG;
      prev_src1 <= 1'b0;
      prev_src2 <= 1'b0;
      prev_src3 <= 1'b0;
      prev_coproc <= 1'b0;
      prev_ext <= 1'b0;
    end else begin
      req_reg <= next_req_reg;
      mask_reg <= next_mask_reg;
      prio_reg <= next_prio_reg;
      mode_reg <= next_mode_reg;
      t0_init <= next_t0_init;
      t1_init <= next_t1_init;
      t0_pre <= next_t0_pre;
      t1_pre <= next_t1_pre;
      o_reg_rdata <= next_rdata;
      prev_src1 <= src1;
      prev_src2 <= src2;
      prev_src3 <= i_port3_line_three;
      prev_coproc <= i_req_from_coprocessor;
      prev_ext <= i_port3_line_one;
    end
  end

  // Timer one source selection
  always_comb begin
    t1_tick = div_tick;
    t1_load = mode_reg[TM_LOAD1];
    next_div_cnt = div_cnt + 2'h1;
    next_timer_output = o_timer_output ^ t1_end; // Toggle on line six
    if (mode_reg[TM_CASCADE]) begin
      t1_tick = t0_end; // Cascade from timer zero
    end else if (mode_reg[TM_T1_EXT]) begin
      // External line use per mode field
      unique case (ext_mode_t'(mode_reg[TM_EXT_HI:TM_EXT_LO]))
        EXT_CLOCK: t1_tick = ext_rise;
        EXT_GATE: t1_tick = div_tick && i_port3_line_one;
        EXT_TRIG_ONCE: t1_load = t1_load || (ext_fall && !t1_running);
        EXT_TRIG_RETRIG: t1_load = t1_load || ext_fall;
      endcase
    end
  end

  // Divider and output pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= 2'h0;
      o_timer_output <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      o_timer_output <= next_timer_output;
    end
  end

  // Timer zero: internal clock only
  counter_timer #(.CNT_W(8), .PRE_W(6)) u_timer_zero (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(div_tick),
    .i_load(mode_reg[TM_LOAD0]),
    .i_enable(mode_reg[TM_EN0]),
    .i_continuous(t0_pre[PRE_CONT]),
    .i_init(t0_init),
    .i_prescale(t0_pre[PRE_VAL_HI:PRE_VAL_LO]),
    .o_count(t0_count),
    .o_end(t0_end),
    .o_running(t0_running)
  );

  // Timer one
  counter_timer #(.CNT_W(8), .PRE_W(6)) u_timer_one (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(t1_tick),
    .i_load(t1_load),
    .i_enable(mode_reg[TM_EN1]),
    .i_continuous(t1_pre[PRE_CONT]),
    .i_init(t1_init),
    .i_prescale(t1_pre[PRE_VAL_HI:PRE_VAL_LO]),
    .o_count(t1_count),
    .o_end(t1_end),
    .o_running(t1_running)
  );

  // Interrupt machine cycle sequencing
  always_comb begin
    next_state = state;
    next_vec_idx = vec_idx;
    next_vec_hi = vec_hi;
    next_handler = o_handler_addr;
    unique case (state)
      S_IDLE: begin
        if (grant) begin
          next_state = S_PUSH_PC;
          next_vec_idx = grant_idx;
        end
      end
      S_PUSH_PC: next_state = S_PUSH_FLAGS; // Program counter first
      S_PUSH_FLAGS: next_state = S_FETCH_HI;
      S_FETCH_HI: next_state = S_FETCH_LO;
      S_FETCH_LO: begin
        next_vec_hi = i_vec_data; // Byte 2n arrives now
        next_state = S_JUMP;
      end
      S_JUMP: begin
        next_handler = {vec_hi, i_vec_data}; // 16-bit address
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE; // Illegal codes recover
    endcase
  end

  // Machine state and strobes, all taken from flip-flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= S_IDLE;
      vec_idx <= 3'h0;
      vec_hi <= 8'h00;
      o_handler_addr <= 16'h0000;
      o_int_cycle <= 1'b0;
      o_push_pc <= 1'b0;
      o_push_flags <= 1'b0;
      o_vec_rd <= 1'b0;
      o_vec_addr <= 16'h0000;
      o_jump <= 1'b0;
    end else begin
      state <= next_state;
      vec_idx <= next_vec_idx;
      vec_hi <= next_vec_hi;
      o_handler_addr <= next_handler;
      o_int_cycle <= (next_state != S_IDLE);
      o_push_pc <= (next_state == S_PUSH_PC);
      o_push_flags <= (next_state == S_PUSH_FLAGS);
      o_vec_rd <= (next_state == S_FETCH_HI) ||
        (next_state == S_FETCH_LO);
      // Vector pair at bytes 2n and 2n+1
      o_vec_addr <= {12'h000, next_vec_idx, next_state == S_FETCH_LO};
      o_jump <= (state == S_JUMP);
    end
  end

endmodule

/* File: test/irq_unit_chk.sv */
// Checker for the interrupt machine cycle and the register read port.
// Assumes it is bound to the unit top and sees only that module's ports.
`timescale 1ns/1ns
module irq_unit_chk
  import irq_timer_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Interrupt cycle
  input wire logic i_instr_boundary,
  input wire logic [7:0] i_vec_data,
  input wire logic o_int_cycle,
  input wire logic o_push_pc,
  input wire logic o_push_flags,
  input wire logic o_vec_rd,
  input wire logic [15:0] o_vec_addr,
  input wire logic [15:0] o_handler_addr,
  input wire logic o_jump
);
  logic armed; // Global enable rewritten since the last grant
  logic next_armed;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // A grant uses up the global enable; only software gives it back
  always_comb begin
    next_armed = armed;
    if (o_push_pc) begin
      next_armed = 1'b0;
    end
    if (i_reg_wr && i_reg_addr == ADDR_MASK) begin
      next_armed = i_reg_wdata[MASK_GLOBAL];
    end
  end

  // Register the tracker
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
    end
  end

  // Stack pushes, then two vector fetches and the jump
  sequence push_s;
    o_push_pc ##1 o_push_flags;
  endsequence
  sequence fetch_s;
    o_vec_rd ##1 o_vec_rd ##2 o_jump;
  endsequence

  int_steps_a: assert property (
    $rose(o_int_cycle) |-> push_s ##1 fetch_s)
    else $error("interrupt cycle steps out of order");
  int_length_a: assert property (
    $rose(o_int_cycle) |-> o_int_cycle [*5] ##1 !o_int_cycle)
    else $error("interrupt cycle length wrong");
  vec_pair_a: assert property (
    $rose(o_vec_rd) |-> (!o_vec_addr[0] && o_vec_addr <= 16'h000A)
    ##1 (o_vec_addr == $past(o_vec_addr) + 16'h0001))
    else $error("vector byte pair address wrong");
  handler_word_a: assert property (
    o_jump |-> o_handler_addr == {$past(i_vec_data, 2), $past(i_vec_data)})
    else $error("handler address not built from vector bytes");
  jump_pulse_a: assert property (
    o_jump |-> !o_int_cycle ##1 !o_jump)
    else $error("jump not a single pulse after the cycle");
  fetch_inside_a: assert property (
    o_vec_rd |-> o_int_cycle)
    else $error("vector fetch outside interrupt cycle");
  grant_boundary_a: assert property (
    $rose(o_int_cycle) |-> $past(i_instr_boundary))
    else $error("grant away from instruction boundary");
  no_regrant_a: assert property (
    $rose(o_int_cycle) |-> armed)
    else $error("grant without global enable");
  pre_hidden_a: assert property (
    ($past(i_reg_addr) == ADDR_T0_PRESCALE ||
     $past(i_reg_addr) == ADDR_T1_PRESCALE) |-> o_reg_rdata == 8'h00)
    else $error("prescaler contents readable");
endmodule

/* File: test/irq_far_side.sv */
// Far side model: port lines, comparators, coprocessor, vector memory.
// Assumes the bench states wanted pin levels; they move on clock edges.
`timescale 1ns/1ns
module irq_far_side
  import irq_timer_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Wanted levels: coproc, comp two, comp one, line three, two, one
  input wire logic [5:0] i_pins,
  // Vector fetch from the unit
  input wire logic i_vec_rd,
  input wire logic [15:0] i_vec_addr,
  // Lines towards the unit
  output logic [5:0] o_pins,
  output logic [7:0] o_vec_data
);
  // Idle high so the first falling edge is a real one
  initial begin
    o_pins = 6'h3F;
    o_vec_data = 8'h00;
  end

  // Coprocessor raises its request by a falling level, like the pins
  always @(posedge i_clk) begin
    o_pins <= i_pins;
  end

  // Byte k of vector memory holds A0 plus k, one clock after the address
  // Outside fetches the bus wobbles so a stale byte never looks valid
  always @(posedge i_clk) begin
    if (i_vec_rd) begin
      o_vec_data <= 8'hA0 + i_vec_addr[7:0];
    end else begin
      o_vec_data <= ~o_vec_data;
    end
  end
endmodule

/* File: test/vectored_irq_and_timer_unit_tb.sv */
// Bench for the interrupt and timer unit, driven through its register port.
// Assumes the far side model for pins and vector memory.
`timescale 1ns/1ns
module vectored_irq_and_timer_unit_tb
  import irq_timer_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] addr = 8'h00; // Register port drive
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [5:0] pins = 6'h3F; // Wanted far side levels
  logic analog = 1'b0;
  logic boundary = 1'b0;
  logic [5:0] lines;
  logic [7:0] rdata, vdata, d, d2;
  logic vrd, icyc, ppc, pfl, jmp, timer_output;
  logic [15:0] vaddr, haddr;
  logic [1:0] sel;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 i_clk = ~i_clk;

  vectored_irq_and_timer_unit u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_port3_line_one(lines[0]),
    .i_port3_line_two(lines[1]), .i_port3_line_three(lines[2]),
    .i_comparator_one_out(lines[3]), .i_comparator_two_out(lines[4]),
    .i_analog_mode(analog), .i_req_from_coprocessor(lines[5]),
    .i_instr_boundary(boundary), .i_vec_data(vdata), .o_int_cycle(icyc),
    .o_push_pc(ppc), .o_push_flags(pfl), .o_vec_rd(vrd),
    .o_vec_addr(vaddr), .o_handler_addr(haddr), .o_jump(jmp),
    .o_timer_output(timer_output));
  irq_far_side u_far (.i_clk(i_clk), .i_pins(pins), .i_vec_rd(vrd),
    .i_vec_addr(vaddr), .o_pins(lines), .o_vec_data(vdata));

  // Report and end; the only exit
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      stop_test();
    end
  end

  // Single compare used by every check
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write strobe lasts exactly one edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  // Read data is registered one cycle behind the address
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    addr <= a;
    @(posedge i_clk);
    #1 v = rdata;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk("register", {8'h00, e}, {8'h00, v});
  endtask
  // Waits for the jump and checks the bytes 2n, 2n+1 it used
  task automatic chk_vec(input logic [7:0] n);
    logic [7:0] b;
    b = 8'hA0 + {n[6:0], 1'b0};
    for (int i = 0; i < 40 && jmp !== 1'b1; i++) @(negedge i_clk);
    chk("handler", {b, b + 8'h01}, haddr);
  endtask
  // Pins settle and edges latch well before the next read
  task automatic set_pins(input logic [5:0] v);
    @(posedge i_clk);
    pins <= v;
    repeat (3) @(posedge i_clk);
  endtask

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_reg(ADDR_REQUEST, 8'h00);
    chk_reg(ADDR_MASK, 8'h00);
    wr_reg(ADDR_T0_PRESCALE, 8'hFD);
    chk_reg(ADDR_T0_PRESCALE, 8'h00);
    wr_reg(8'h10, 8'hFF);
    chk_reg(8'h10, 8'h00);
    // Line three: falling latches, masked yet visible; rising ignored
    set_pins(6'h3B);
    chk_reg(ADDR_REQUEST, 8'h02);
    wr_reg(ADDR_REQUEST, 8'h00);
    set_pins(6'h3F);
    chk_reg(ADDR_REQUEST, 8'h00);
    // Every edge select code, both directions on lines one and two
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      wr_reg(ADDR_REQUEST, {sel, 6'h00});
      set_pins(6'h3C);
      chk_reg(ADDR_REQUEST, {sel, 3'b000, sel != 2'b10, 1'b0,
                             sel != 2'b01});
      wr_reg(ADDR_REQUEST, {sel, 6'h00});
      set_pins(6'h3F);
      chk_reg(ADDR_REQUEST, {sel, 3'b000, sel[1], 1'b0, sel[0]});
    end
    // Comparators stand in for lines one and two
    wr_reg(ADDR_REQUEST, 8'h00);
    analog <= 1'b1;
    set_pins(6'h27);
    chk_reg(ADDR_REQUEST, 8'h05);
    set_pins(6'h3F);
    analog <= 1'b0;
    wr_reg(ADDR_REQUEST, 8'h00);
    // Coprocessor request: set by falling level, cleared by writing one
    set_pins(6'h1F);
    chk_reg(ADDR_COPROC_CTRL, 8'h01);
    chk_reg(ADDR_REQUEST, 8'h08);
    wr_reg(ADDR_COPROC_CTRL, 8'h01);
    chk_reg(ADDR_COPROC_CTRL, 8'h00);
    set_pins(6'h3F);
    chk_reg(ADDR_REQUEST, 8'h00);
    // Two pending; priority 2 wraps round to request 0
    set_pins(6'h39);
    set_pins(6'h3F);
    wr_reg(ADDR_PRIORITY, 8'h02);
    wr_reg(ADDR_MASK, 8'h83);
    repeat (10) @(posedge i_clk);
    chk_reg(ADDR_REQUEST, 8'h03);
    boundary <= 1'b1;
    chk_vec(8'h00);
    chk_reg(ADDR_MASK, 8'h03);
    chk_reg(ADDR_REQUEST, 8'h02);
    // Both pending again; priority 1 picks request 1
    wr_reg(ADDR_PRIORITY, 8'h01);
    set_pins(6'h3D);
    set_pins(6'h3F);
    wr_reg(ADDR_MASK, 8'h83);
    chk_vec(8'h01);
    // Individually masked request stays pending
    wr_reg(ADDR_MASK, 8'h82);
    repeat (10) @(posedge i_clk);
    chk_reg(ADDR_REQUEST, 8'h01);
    wr_reg(ADDR_MASK, 8'h00);
    wr_reg(ADDR_REQUEST, 8'h00);
    // Both timers single pass, divide by one, counts 3 and 1
    wr_reg(ADDR_T0_PRESCALE, 8'h04);
    wr_reg(ADDR_T0_COUNT, 8'h03);
    wr_reg(ADDR_T1_PRESCALE, 8'h04);
    wr_reg(ADDR_T1_COUNT, 8'h01);
    wr_reg(ADDR_TIMER_MODE, 8'h0F);
    repeat (60) @(posedge i_clk);
    chk_reg(ADDR_REQUEST, 8'h30);
    chk_reg(ADDR_T0_COUNT, 8'h00);
    chk("timer out", 16'h0001, {15'h0000, timer_output});
    wr_reg(ADDR_REQUEST, 8'h00);
    repeat (40) @(posedge i_clk);
    chk_reg(ADDR_REQUEST, 8'h00);
    // Continuous: end of count comes again after a clear
    wr_reg(ADDR_T0_PRESCALE, 8'h05);
    wr_reg(ADDR_TIMER_MODE, 8'h03);
    repeat (30) @(posedge i_clk);
    wr_reg(ADDR_REQUEST, 8'h00);
    repeat (30) @(posedge i_clk);
    chk_reg(ADDR_REQUEST, 8'h10);
    // Stop holds the count, continue resumes, load restarts
    wr_reg(ADDR_T0_COUNT, 8'h50);
    wr_reg(ADDR_TIMER_MODE, 8'h03);
    repeat (20) @(posedge i_clk);
    wr_reg(ADDR_TIMER_MODE, 8'h00);
    rd_reg(ADDR_T0_COUNT, d);
    repeat (20) @(posedge i_clk);
    chk_reg(ADDR_T0_COUNT, d);
    wr_reg(ADDR_TIMER_MODE, 8'h02);
    repeat (20) @(posedge i_clk);
    rd_reg(ADDR_T0_COUNT, d2);
    chk("resume", 16'h0001, {15'h0000, d2 < d && d2 > d - 8'h09});
    wr_reg(ADDR_TIMER_MODE, 8'h03);
    rd_reg(ADDR_T0_COUNT, d2);
    chk("reload", 16'h0001, {15'h0000, d2 > 8'h4C});
    // Cascade holds timer one until timer zero ends; then one line edge
    wr_reg(ADDR_T1_COUNT, 8'h02);
    wr_reg(ADDR_TIMER_MODE, 8'h8C);
    repeat (20) @(posedge i_clk);
    chk_reg(ADDR_T1_COUNT, 8'h02);
    wr_reg(ADDR_T0_COUNT, 8'h03);
    wr_reg(ADDR_TIMER_MODE, 8'h8B);
    repeat (60) @(posedge i_clk);
    chk_reg(ADDR_REQUEST, 8'h30);
    wr_reg(ADDR_TIMER_MODE, 8'h4C);
    set_pins(6'h3E);
    set_pins(6'h3F);
    chk_reg(ADDR_T1_COUNT, 8'h01);
    stop_test();
  end
endmodule

bind vectored_irq_and_timer_unit irq_unit_chk u_chk (.i_clk(i_clk),
  .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_instr_boundary(i_instr_boundary), .i_vec_data(i_vec_data),
  .o_int_cycle(o_int_cycle), .o_push_pc(o_push_pc),
  .o_push_flags(o_push_flags), .o_vec_rd(o_vec_rd),
  .o_vec_addr(o_vec_addr), .o_handler_addr(o_handler_addr),
  .o_jump(o_jump));
